// ---- shared/tx_cfg_pkg.sv ----
// Transmit path configuration register map and field layout
package tx_cfg_pkg;
  localparam int          DATA_W            = 8;
  localparam int          ADDR_W            = 8;
  // Register addresses, equal to the register numbers
  localparam logic [7:0]  ADDR_PATH_CONTROL = 8'h0A;
  localparam logic [7:0]  ADDR_GAIN_SHAPING = 8'h0B;
  localparam logic [7:0]  ADDR_MOD_LEVEL    = 8'h0C;
  localparam logic [7:0]  ADDR_OUTPUT_MODE  = 8'h0D;
  localparam logic [7:0]  ADDR_CROSSPOINT   = 8'h0E;
  localparam logic [7:0]  REG_RESET         = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ     = 8'h00;
  // Path control bits
  localparam int          BIT_POWER_DOWN    = 7;
  localparam int          BIT_DRIVER_OFF    = 6;
  localparam int          BIT_INVERT_OUTPUT = 5;
  localparam int          BIT_RECOVERY_OFF  = 4;
  localparam int          BIT_RECOVERY_SKIP = 3;
  localparam int          BIT_OFFSET_OFF    = 2;
  localparam int          BIT_EQUALIZER_OFF = 1;
  localparam int          BIT_ANALOG_SWING  = 0;
  // Gain shaping fields
  localparam int          BIT_HALF_SWING    = 7;
  localparam int          BIT_PEAKING_WIDE  = 6;
  localparam int          TEMPCOMP_MSB      = 5;
  localparam int          TEMPCOMP_LSB      = 4;
  localparam int          INPUT_EQ_MSB      = 3;
  localparam int          INPUT_EQ_LSB      = 0;
  // Output mode fields
  localparam int          BIT_SIDE_SEL      = 7;
  localparam int          BIT_SINGLE_ENDED  = 6;
  localparam int          BIT_DELAYED_DEEMPH = 5;
  localparam int          BIT_SLOW_EDGES    = 4;
  localparam int          DEEMPH_MSB        = 3;
  localparam int          DEEMPH_LSB        = 0;
  // Crosspoint fields
  localparam int          BIT_CP_SIGN       = 7;
  localparam int          CP_SIZE_MSB       = 6;
  localparam int          CP_SIZE_LSB       = 0;
endpackage

// ---- logic/tx_path_config_registers.sv ----
// Transmit path configuration register bank with decoded settings
`timescale 1ns/1ps
// Operation
// - Control bit 7 set powers down the whole transmit path.
// - Control bit 6 set disables the transmit output driver.
// - Control bit 5 set inverts transmitted output polarity.
// - Control bit 4 set disables and bypasses transmit clock recovery.
// - Control bit 3 bypass acts only while receive bypass is also set.
// - Control bit 2 set turns off transmit offset cancellation.
// - Control bit 1 set disables and bypasses the input equalizer.
// - Control bit 0 picks analog swing control, else digital.
// - Shaping bit 7 set limits output swing to half range.
// - Shaping bit 6 set selects wide peaking, else narrow.
// - Shaping bits 5:4 select temperature compensation, bit 5 upper.
// - Shaping bits 3:0 set input equalizer, 0000 weakest.
// - Eight-bit modulation level sets swing, about 9.5 mVpp per step.
// - Mode bit 6 set selects single-ended drive, else differential.
// - In single-ended mode bit 7 picks negative, else positive.
// - Mode bit 5 delays de-emphasis; bits 3:0 set its strength.
// - Mode bit 4 set slows output edges.
// - Crosspoint bit 7 gives shift sign; bits 6:0 its size.
// - Every field is read/write and resets to zero.
module tx_path_config_registers
#(
  parameter int DATA_W = tx_cfg_pkg::DATA_W
)
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  input  wire logic [7:0]        i_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_rx_recovery_skip,
  output logic      [DATA_W-1:0] o_rd_data,
  output logic                   o_rd_valid,
  output logic                   o_tx_path_enable,
  output logic                   o_tx_driver_enable,
  output logic                   o_tx_invert_output,
  output logic                   o_tx_recovery_enable,
  output logic                   o_tx_recovery_bypass,
  output logic                   o_tx_offset_cancel_enable,
  output logic                   o_tx_equalizer_enable,
  output logic                   o_tx_analog_swing_sel,
  output logic                   o_tx_half_swing,
  output logic                   o_tx_peaking_wide,
  output logic      [1:0]        o_tx_tempcomp_sel,
  output logic      [3:0]        o_tx_input_eq_level,
  output logic      [7:0]        o_tx_swing_level,
  output logic                   o_tx_single_ended,
  output logic                   o_tx_drive_pos,
  output logic                   o_tx_drive_neg,
  output logic                   o_tx_delayed_deemph,
  output logic                   o_tx_slow_edges,
  output logic      [3:0]        o_tx_deemph_level,
  output logic                   o_tx_crosspoint_sign,
  output logic      [6:0]        o_tx_crosspoint_size
);

  // Refuse widths and layouts that the decode cannot serve
  if (DATA_W != 8)
  begin : g_bad_width
    $error("DATA_W must be 8");
  end

  // Every single-bit field must sit inside the register word
  if (tx_cfg_pkg::BIT_POWER_DOWN     >= DATA_W ||
      tx_cfg_pkg::BIT_DRIVER_OFF     >= DATA_W ||
      tx_cfg_pkg::BIT_INVERT_OUTPUT  >= DATA_W ||
      tx_cfg_pkg::BIT_RECOVERY_OFF   >= DATA_W ||
      tx_cfg_pkg::BIT_RECOVERY_SKIP  >= DATA_W ||
      tx_cfg_pkg::BIT_OFFSET_OFF     >= DATA_W ||
      tx_cfg_pkg::BIT_EQUALIZER_OFF  >= DATA_W ||
      tx_cfg_pkg::BIT_ANALOG_SWING   >= DATA_W ||
      tx_cfg_pkg::BIT_HALF_SWING     >= DATA_W ||
      tx_cfg_pkg::BIT_PEAKING_WIDE   >= DATA_W ||
      tx_cfg_pkg::BIT_SIDE_SEL       >= DATA_W ||
      tx_cfg_pkg::BIT_SINGLE_ENDED   >= DATA_W ||
      tx_cfg_pkg::BIT_DELAYED_DEEMPH >= DATA_W ||
      tx_cfg_pkg::BIT_SLOW_EDGES     >= DATA_W ||
      tx_cfg_pkg::BIT_CP_SIGN        >= DATA_W)
  begin : g_bad_bit_pos
    $error("Single-bit field outside the register word");
  end

  // Multi-bit fields must match the widths of their outputs
  if (tx_cfg_pkg::TEMPCOMP_MSB - tx_cfg_pkg::TEMPCOMP_LSB != 1 ||
      tx_cfg_pkg::INPUT_EQ_MSB - tx_cfg_pkg::INPUT_EQ_LSB != 3 ||
      tx_cfg_pkg::DEEMPH_MSB   - tx_cfg_pkg::DEEMPH_LSB   != 3 ||
      tx_cfg_pkg::CP_SIZE_MSB  - tx_cfg_pkg::CP_SIZE_LSB  != 6 ||
      tx_cfg_pkg::TEMPCOMP_MSB >= DATA_W ||
      tx_cfg_pkg::INPUT_EQ_MSB >= DATA_W ||
      tx_cfg_pkg::DEEMPH_MSB   >= DATA_W ||
      tx_cfg_pkg::CP_SIZE_MSB  >= DATA_W)
  begin : g_bad_field
    $error("Multi-bit field does not fit its output");
  end

  // Overlapping addresses would let one register shadow another
  if (tx_cfg_pkg::ADDR_PATH_CONTROL == tx_cfg_pkg::ADDR_GAIN_SHAPING ||
      tx_cfg_pkg::ADDR_PATH_CONTROL == tx_cfg_pkg::ADDR_MOD_LEVEL    ||
      tx_cfg_pkg::ADDR_PATH_CONTROL == tx_cfg_pkg::ADDR_OUTPUT_MODE  ||
      tx_cfg_pkg::ADDR_PATH_CONTROL == tx_cfg_pkg::ADDR_CROSSPOINT   ||
      tx_cfg_pkg::ADDR_GAIN_SHAPING == tx_cfg_pkg::ADDR_MOD_LEVEL    ||
      tx_cfg_pkg::ADDR_GAIN_SHAPING == tx_cfg_pkg::ADDR_OUTPUT_MODE  ||
      tx_cfg_pkg::ADDR_GAIN_SHAPING == tx_cfg_pkg::ADDR_CROSSPOINT   ||
      tx_cfg_pkg::ADDR_MOD_LEVEL    == tx_cfg_pkg::ADDR_OUTPUT_MODE  ||
      tx_cfg_pkg::ADDR_MOD_LEVEL    == tx_cfg_pkg::ADDR_CROSSPOINT   ||
      tx_cfg_pkg::ADDR_OUTPUT_MODE  == tx_cfg_pkg::ADDR_CROSSPOINT)
  begin : g_bad_map
    $error("Register addresses must be distinct");
  end

  logic [7:0] path_control;
  logic [7:0] gain_shaping;
  logic [7:0] mod_level;
  logic [7:0] output_mode;
  logic [7:0] crosspoint;
  logic [7:0] next_path_control;
  logic [7:0] next_gain_shaping;
  logic [7:0] next_mod_level;
  logic [7:0] next_output_mode;
  logic [7:0] next_crosspoint;
  logic [7:0] next_rd_data;
  logic       next_rd_valid;

  // Register writes and read mux
  always_comb
  begin
    next_path_control = path_control;
    next_gain_shaping = gain_shaping;
    next_mod_level    = mod_level;
    next_output_mode  = output_mode;
    next_crosspoint   = crosspoint;
    next_rd_data      = o_rd_data;
    next_rd_valid     = 1'b0;
    if (i_wr_en)
    begin
      case (i_addr)
        tx_cfg_pkg::ADDR_PATH_CONTROL: next_path_control = i_wr_data;
        tx_cfg_pkg::ADDR_GAIN_SHAPING: next_gain_shaping = i_wr_data;
        tx_cfg_pkg::ADDR_MOD_LEVEL:    next_mod_level    = i_wr_data;
        tx_cfg_pkg::ADDR_OUTPUT_MODE:  next_output_mode  = i_wr_data;
        tx_cfg_pkg::ADDR_CROSSPOINT:   next_crosspoint   = i_wr_data;
        default:                       next_crosspoint   = crosspoint;
      endcase
    end
    else if (i_rd_en)
    begin
      next_rd_valid = 1'b1;
      case (i_addr)
        tx_cfg_pkg::ADDR_PATH_CONTROL: next_rd_data = path_control;
        tx_cfg_pkg::ADDR_GAIN_SHAPING: next_rd_data = gain_shaping;
        tx_cfg_pkg::ADDR_MOD_LEVEL:    next_rd_data = mod_level;
        tx_cfg_pkg::ADDR_OUTPUT_MODE:  next_rd_data = output_mode;
        tx_cfg_pkg::ADDR_CROSSPOINT:   next_rd_data = crosspoint;
        default:                       next_rd_data = tx_cfg_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      path_control <= tx_cfg_pkg::REG_RESET;
      gain_shaping <= tx_cfg_pkg::REG_RESET;
      mod_level    <= tx_cfg_pkg::REG_RESET;
      output_mode  <= tx_cfg_pkg::REG_RESET;
      crosspoint   <= tx_cfg_pkg::REG_RESET;
      o_rd_data    <= tx_cfg_pkg::REG_RESET;
      o_rd_valid   <= 1'b0;
    end
    else
    begin
      path_control <= next_path_control;
      gain_shaping <= next_gain_shaping;
      mod_level    <= next_mod_level;
      output_mode  <= next_output_mode;
      crosspoint   <= next_crosspoint;
      o_rd_data    <= next_rd_data;
      o_rd_valid   <= next_rd_valid;
    end
  end

  // Decoded settings, taken from the next register values
  logic       next_path_enable;
  logic       next_driver_enable;
  logic       next_invert_output;
  logic       next_recovery_enable;
  logic       next_recovery_bypass;
  logic       next_offset_enable;
  logic       next_equalizer_enable;
  logic       next_analog_swing;
  logic       next_half_swing;
  logic       next_peaking_wide;
  logic [1:0] next_tempcomp;
  logic [3:0] next_input_eq;
  logic [7:0] next_swing;
  logic       next_single_ended;
  logic       next_drive_pos;
  logic       next_drive_neg;
  logic       next_delayed_deemph;
  logic       next_slow_edges;
  logic [3:0] next_deemph;
  logic       next_cp_sign;
  logic [6:0] next_cp_size;

  always_comb
  begin
    next_path_enable      =
      !next_path_control[tx_cfg_pkg::BIT_POWER_DOWN];
    next_driver_enable    = next_path_enable &&
      !next_path_control[tx_cfg_pkg::BIT_DRIVER_OFF];
    next_invert_output    =
      next_path_control[tx_cfg_pkg::BIT_INVERT_OUTPUT];
    next_recovery_enable  = next_path_enable &&
      !next_path_control[tx_cfg_pkg::BIT_RECOVERY_OFF];
    next_recovery_bypass  =
      next_path_control[tx_cfg_pkg::BIT_RECOVERY_OFF] ||
      (next_path_control[tx_cfg_pkg::BIT_RECOVERY_SKIP] &&
       i_rx_recovery_skip);
    next_offset_enable    = next_path_enable &&
      !next_path_control[tx_cfg_pkg::BIT_OFFSET_OFF];
    next_equalizer_enable = next_path_enable &&
      !next_path_control[tx_cfg_pkg::BIT_EQUALIZER_OFF];
    next_analog_swing     =
      next_path_control[tx_cfg_pkg::BIT_ANALOG_SWING];
    next_half_swing       =
      next_gain_shaping[tx_cfg_pkg::BIT_HALF_SWING];
    next_peaking_wide     =
      next_gain_shaping[tx_cfg_pkg::BIT_PEAKING_WIDE];
    next_tempcomp         = next_gain_shaping[
      tx_cfg_pkg::TEMPCOMP_MSB:tx_cfg_pkg::TEMPCOMP_LSB];
    next_input_eq         = next_gain_shaping[
      tx_cfg_pkg::INPUT_EQ_MSB:tx_cfg_pkg::INPUT_EQ_LSB];
    next_swing            = next_mod_level;
    next_single_ended     =
      next_output_mode[tx_cfg_pkg::BIT_SINGLE_ENDED];
    next_drive_pos        = next_driver_enable &&
      (!next_single_ended ||
       !next_output_mode[tx_cfg_pkg::BIT_SIDE_SEL]);
    next_drive_neg        = next_driver_enable &&
      (!next_single_ended ||
       next_output_mode[tx_cfg_pkg::BIT_SIDE_SEL]);
    next_delayed_deemph   =
      next_output_mode[tx_cfg_pkg::BIT_DELAYED_DEEMPH];
    next_deemph           = next_output_mode[tx_cfg_pkg::DEEMPH_MSB:
                                             tx_cfg_pkg::DEEMPH_LSB];
    next_slow_edges       =
      next_output_mode[tx_cfg_pkg::BIT_SLOW_EDGES];
    next_cp_sign          = next_crosspoint[tx_cfg_pkg::BIT_CP_SIGN];
    next_cp_size          = next_crosspoint[tx_cfg_pkg::CP_SIZE_MSB:
                                            tx_cfg_pkg::CP_SIZE_LSB];
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_tx_path_enable          <= 1'b1;
      o_tx_driver_enable        <= 1'b1;
      o_tx_invert_output        <= 1'b0;
      o_tx_recovery_enable      <= 1'b1;
      o_tx_recovery_bypass      <= 1'b0;
      o_tx_offset_cancel_enable <= 1'b1;
      o_tx_equalizer_enable     <= 1'b1;
      o_tx_analog_swing_sel     <= 1'b0;
      o_tx_half_swing           <= 1'b0;
      o_tx_peaking_wide         <= 1'b0;
      o_tx_tempcomp_sel         <= 2'h0;
      o_tx_input_eq_level       <= 4'h0;
      o_tx_swing_level          <= 8'h00;
      o_tx_single_ended         <= 1'b0;
      o_tx_drive_pos            <= 1'b1;
      o_tx_drive_neg            <= 1'b1;
      o_tx_delayed_deemph       <= 1'b0;
      o_tx_slow_edges           <= 1'b0;
      o_tx_deemph_level         <= 4'h0;
      o_tx_crosspoint_sign      <= 1'b0;
      o_tx_crosspoint_size      <= 7'h00;
    end
    else
    begin
      o_tx_path_enable          <= next_path_enable;
      o_tx_driver_enable        <= next_driver_enable;
      o_tx_invert_output        <= next_invert_output;
      o_tx_recovery_enable      <= next_recovery_enable;
      o_tx_recovery_bypass      <= next_recovery_bypass;
      o_tx_offset_cancel_enable <= next_offset_enable;
      o_tx_equalizer_enable     <= next_equalizer_enable;
      o_tx_analog_swing_sel     <= next_analog_swing;
      o_tx_half_swing           <= next_half_swing;
      o_tx_peaking_wide         <= next_peaking_wide;
      o_tx_tempcomp_sel         <= next_tempcomp;
      o_tx_input_eq_level       <= next_input_eq;
      o_tx_swing_level          <= next_swing;
      o_tx_single_ended         <= next_single_ended;
      o_tx_drive_pos            <= next_drive_pos;
      o_tx_drive_neg            <= next_drive_neg;
      o_tx_delayed_deemph       <= next_delayed_deemph;
      o_tx_slow_edges           <= next_slow_edges;
      o_tx_deemph_level         <= next_deemph;
      o_tx_crosspoint_sign      <= next_cp_sign;
      o_tx_crosspoint_size      <= next_cp_size;
    end
  end

endmodule

// ---- testbench/tx_path_config_asserts.sv ----
// Checks on the transmit configuration register port
`timescale 1ns/1ps
module tx_path_config_asserts (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_b,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_rx_recovery_skip,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic       o_tx_path_enable,
  input wire logic       o_tx_driver_enable,
  input wire logic       o_tx_recovery_enable,
  input wire logic       o_tx_recovery_bypass
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_ctl; i_wr_en && i_addr == 8'h0A; endsequence
  sequence s_rd; i_rd_en && !i_wr_en; endsequence
  a_power_down: assert property (s_ctl |=>
    o_tx_path_enable == !$past(i_wr_data[7])) else $error("path on");
  a_driver_off: assert property (s_ctl |=> o_tx_driver_enable ==
    !($past(i_wr_data[7]) || $past(i_wr_data[6]))) else $error("driver");
  a_recovery_off: assert property (s_ctl ##0 i_wr_data[4] |=>
    o_tx_recovery_bypass && !o_tx_recovery_enable) else $error("recovery");
  a_skip_needs_rx: assert property (o_tx_recovery_bypass &&
    o_tx_recovery_enable |-> $past(i_rx_recovery_skip)) else $error("skip");
  a_read_pulse: assert property (o_rd_valid ==
    $past(i_rd_en && !i_wr_en)) else $error("read valid");
  a_write_readback: assert property (i_wr_en && i_addr > 8'h09 &&
    i_addr < 8'h0F ##1 s_rd ##0 i_addr == $past(i_addr) |=>
    o_rd_data == $past(i_wr_data, 2)) else $error("read back");
  a_unmapped_zero: assert property (s_rd ##0 (i_addr < 8'h0A ||
    i_addr > 8'h0E) |=> o_rd_data == 8'h00) else $error("unmapped");
  a_hold_setting: assert property (!i_wr_en |=>
    $stable(o_tx_driver_enable)) else $error("drift");
endmodule
bind tx_path_config_registers tx_path_config_asserts u_asserts (.*);

// ---- testbench/tx_host_model.sv ----
// Host controller model driving the register request port
`timescale 1ns/1ps
module tx_host_model (
  input  wire logic       i_clk_sys,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wr_data,
  output logic            o_rx_skip
);
  task automatic req(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d, input logic s);
    o_wr_en = w;
    o_rd_en = r;
    o_addr = a;
    o_wr_data = d;
    o_rx_skip = s;
    @(posedge i_clk_sys) #1;
  endtask
endmodule

// ---- testbench/test_tx_path_config_registers.sv ----
// Self-checking bench for the transmit configuration register bank
`timescale 1ns/1ps
module test_tx_path_config_registers;
  logic        i_clk_sys = 1'b0, i_rst_b = 1'b0;
  logic        i_wr_en, i_rd_en, i_rx_recovery_skip, dr;
  logic        o_rd_valid, o_tx_path_enable, o_tx_driver_enable;
  logic        o_tx_invert_output, o_tx_recovery_enable, o_tx_recovery_bypass;
  logic        o_tx_offset_cancel_enable, o_tx_equalizer_enable;
  logic        o_tx_analog_swing_sel, o_tx_half_swing, o_tx_peaking_wide;
  logic        o_tx_single_ended, o_tx_drive_pos, o_tx_drive_neg;
  logic        o_tx_delayed_deemph, o_tx_slow_edges, o_tx_crosspoint_sign;
  logic [1:0]  o_tx_tempcomp_sel;
  logic [3:0]  o_tx_input_eq_level, o_tx_deemph_level;
  logic [6:0]  o_tx_crosspoint_size;
  logic [7:0]  i_addr, i_wr_data, o_rd_data, o_tx_swing_level, a, d;
  logic [7:0]  m [5] = '{default: 8'h00};
  logic [15:0] cor [5] = '{16'h0A80, 16'h0A50, 16'h0A08, 16'h0DC0, 16'h0EFF};
  int          failures, compares, r, seed = 32'h41E39DAF;
  tx_path_config_registers DUT (.*);
  tx_host_model host (.i_clk_sys, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_addr(i_addr), .o_wr_data(i_wr_data), .o_rx_skip(i_rx_recovery_skip));
  initial forever #4 i_clk_sys = ~i_clk_sys;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [7:0] exp_ctl(input logic [7:0] c, input logic s);
    exp_ctl = {~c[7], ~(c[7] | c[6]), c[5], ~(c[7] | c[4]),
               c[4] | (c[3] & s), ~(c[7] | c[2]), ~(c[7] | c[1]), c[0]};
  endfunction
  task automatic check_all();
    dr = ~(m[0][7] | m[0][6]);
    chk(16'({o_tx_path_enable, o_tx_driver_enable, o_tx_invert_output,
      o_tx_recovery_enable, o_tx_recovery_bypass, o_tx_offset_cancel_enable,
      o_tx_equalizer_enable, o_tx_analog_swing_sel}),
      16'(exp_ctl(m[0], i_rx_recovery_skip)));
    chk({o_tx_half_swing, o_tx_peaking_wide, o_tx_tempcomp_sel,
      o_tx_input_eq_level, o_tx_swing_level}, {m[1], m[2]});
    chk(16'({o_tx_crosspoint_sign, o_tx_crosspoint_size}), 16'(m[4]));
    chk(16'({o_tx_single_ended, o_tx_drive_pos, o_tx_drive_neg,
      o_tx_delayed_deemph, o_tx_slow_edges, o_tx_deemph_level}),
      16'({m[3][6], dr & ~(m[3][6] & m[3][7]), dr & ~(m[3][6] & ~m[3][7]),
      m[3][5:0]}));
  endtask
  task automatic rd_check(input logic [7:0] ra, input logic [7:0] e);
    host.req(1'b0, 1'b1, ra, ~ra, i_rx_recovery_skip);
    chk(16'({o_rd_valid, o_rd_data}), 16'({1'b1, e}));
  endtask
  initial
  begin
    repeat (8) host.req(1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    i_rst_b = 1'b1;
    for (int k = 0; k < 5; k++)
      rd_check(8'h0A + 8'(k), 8'h00);
    check_all();
    $display("reset values test done");
    for (int k = 0; k < 60; k++)
    begin
      r = $random(seed);
      a = (k < 5) ? cor[k][15:8] : 8'h09 + 8'(r[18:16]);
      d = (k < 5) ? cor[k][7:0] : r[7:0];
      host.req(1'b1, 1'b0, a, d, r[20]);
      if (a inside {[8'h0A:8'h0E]})
        m[a - 8'h0A] = d;
      rd_check(a, (a inside {[8'h0A:8'h0E]}) ? m[a - 8'h0A]
        : tx_cfg_pkg::UNMAPPED_READ);
      check_all();
    end
    host.req(1'b1, 1'b1, 8'h0C, 8'hA5, 1'b0);
    m[2] = 8'hA5;
    chk(16'(o_rd_valid), 16'h0000);
    check_all();
    $display("random and corner test done");
    i_rst_b = 1'b0;
    m = '{default: 8'h00};
    host.req(1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    check_all();
    i_rst_b = 1'b1;
    rd_check(8'h0C, 8'h00);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
